// ### src/smblm_top.sv
// byte-lane and pin multiplexing layer of a static memory controller external bus
//
// Overview of operation
// - drive a 24-line address bus, 16 Mbytes window per chip select.
// - smaller memories ignore upper bits, so contents alias through the window.
// - each chip select picks 8-bit or 16-bit data bus by its width bit.
// - 16-bit chip selects write in byte-write or byte-select style per access-type bit.
// - byte-write style: one shared read strobe, lower and upper byte write strobes.
// - booting from a byte-write style chip select is not supported.
// - byte-select style: one read strobe, one write strobe, two byte-select lines.
// - 16-bit: address bit 0 unused; unused strobe or select stays inactive.
// - three shared pins carry select/A0, write strobe, upper select/write.
// - address lines 22 and 21 double as flash command and address latch.
// - four independent chip selects, each with own width and access type.
// - chip selects, read, write strobes and byte selects are active low.
`timescale 1ns/1ns
module smblm_top #(
    parameter int unsigned NUM_CS = smblm_pkg::NUM_CS,
    parameter logic [smblm_pkg::MODE_W-1:0] BOOT_MODE = 2'h0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // per chip select mode: bit 0 bus_width_select, bit 1 byte_access_type
    input wire logic [NUM_CS*smblm_pkg::MODE_W-1:0] per_cs_mode_config,
    input wire logic boot_active,
    // one access per cycle: strobe phase driven by the waveform engine
    input wire logic acc_valid,
    input wire logic [$clog2(NUM_CS)-1:0] acc_cs,
    input wire logic [smblm_pkg::SYS_ADDR_W-1:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic acc_write,
    input wire logic acc_rd_pulse,
    input wire logic acc_wr_pulse,
    input wire logic [smblm_pkg::DATA_W-1:0] acc_wdata,
    input wire logic flash_cmd_phase,
    input wire logic flash_addr_phase,
    input wire logic [smblm_pkg::DATA_W-1:0] data_in,
    output logic [smblm_pkg::DATA_W-1:0] rdata,
    output logic [smblm_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic [smblm_pkg::ADDR_W-1:0] addr_pins,
    output logic [NUM_CS-1:0] chip_select_lines_n,
    output logic read_strobe_n,
    output logic sel0_or_a0,
    output logic write_strobe_n,
    output logic upper_sel_or_wr_n,
    output logic flash_command_latch,
    output logic flash_address_latch,
    output logic boot_cfg_error
);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic logic is_wide(input logic [smblm_pkg::MODE_W-1:0] m);
        return m[smblm_pkg::MODE_BUS_WIDTH_BIT] == smblm_pkg::BW_16;
    endfunction

    function automatic logic is_bytewrite(input logic [smblm_pkg::MODE_W-1:0] m);
        return is_wide(m) && (m[smblm_pkg::MODE_BYTE_ACCESS_BIT] == smblm_pkg::BAT_WRITE);
    endfunction

    logic [smblm_pkg::MODE_W-1:0] cs_mode [NUM_CS];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CS; gi++) begin : g_mode
            assign cs_mode[gi] = per_cs_mode_config[gi*smblm_pkg::MODE_W +: smblm_pkg::MODE_W];
        end
    endgenerate

    // decoded once per chip select so the access path only picks a flag
    logic [NUM_CS-1:0] cs_wide;
    logic [NUM_CS-1:0] cs_bytewrite;
    generate
        for (gi = 0; gi < NUM_CS; gi++) begin : g_decode
            assign cs_wide[gi] = is_wide(cs_mode[gi]);
            assign cs_bytewrite[gi] = is_bytewrite(cs_mode[gi]);
        end
    endgenerate

    // boot fetches run as an 8-bit chip select, whatever the mode inputs say
    logic wide;
    logic bytewrite;
    logic boot_bad;
    assign boot_bad = boot_active && is_bytewrite(BOOT_MODE);
    assign wide = !boot_active && cs_wide[acc_cs];
    assign bytewrite = !boot_active && cs_bytewrite[acc_cs];

    // ------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------
    logic lane_lo;
    logic lane_hi;
    always_comb begin
        if (!wide) begin
            lane_lo = 1'b1;
            lane_hi = 1'b0;
        end else if (acc_size == smblm_pkg::SIZE_BYTE) begin
            lane_lo = ~acc_addr[0];
            lane_hi = acc_addr[0];
        end else begin
            lane_lo = 1'b1;
            lane_hi = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // write data lanes
    // ------------------------------------------------------------
    // an upper-lane byte is copied to both lanes, so either byte strobe finds it
    logic [smblm_pkg::DATA_W-1:0] wdata_lane;
    always_comb begin
        if (wide && acc_size == smblm_pkg::SIZE_BYTE && acc_addr[0]) begin
            wdata_lane = {acc_wdata[7:0], acc_wdata[7:0]};
        end else begin
            wdata_lane = acc_wdata;
        end
    end

    // ------------------------------------------------------------
    // pin values before the output flops
    // ------------------------------------------------------------
    logic [smblm_pkg::ADDR_W-1:0] addr_d;
    logic [NUM_CS-1:0] cs_d;
    logic rd_d;
    logic p0_d;
    logic p1_d;
    logic p2_d;
    always_comb begin
        // upper system bits beyond 24 dropped: each window is 16 Mbytes and small parts alias
        addr_d = acc_addr[smblm_pkg::ADDR_W-1:0];
        if (flash_cmd_phase) begin
            addr_d[smblm_pkg::CLE_BIT] = 1'b1;
        end
        if (flash_addr_phase) begin
            addr_d[smblm_pkg::ALE_BIT] = 1'b1;
        end
        cs_d = '1;
        rd_d = 1'b1;
        p0_d = 1'b1;
        p1_d = 1'b1;
        p2_d = 1'b1;
        if (acc_valid && !boot_bad) begin
            cs_d[acc_cs] = 1'b0;
            rd_d = ~(acc_rd_pulse && !acc_write);
            if (!wide) begin
                p0_d = acc_addr[0];
                p1_d = ~(acc_wr_pulse && acc_write);
                p2_d = 1'b1;
            end else if (bytewrite) begin
                p0_d = 1'b1;
                p1_d = ~(acc_wr_pulse && acc_write && lane_lo);
                p2_d = ~(acc_wr_pulse && acc_write && lane_hi);
            end else begin
                // selects follow address timing, so they qualify reads too
                p0_d = ~lane_lo;
                p1_d = ~(acc_wr_pulse && acc_write);
                p2_d = ~lane_hi;
            end
        end else if (wide) begin
            // an idle 16-bit chip select must not leave its lower byte select active
            p0_d = 1'b1;
        end else begin
            p0_d = acc_addr[0];
        end
        if (wide) begin
            addr_d[0] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output flops, one block per pin group
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_pins <= smblm_pkg::ADDR_RST;
        end else if (clk_en) begin
            addr_pins <= addr_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chip_select_lines_n <= '1;
        end else if (clk_en) begin
            chip_select_lines_n <= cs_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            read_strobe_n <= 1'b1;
        end else if (clk_en) begin
            read_strobe_n <= rd_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel0_or_a0 <= 1'b1;
            write_strobe_n <= 1'b1;
            upper_sel_or_wr_n <= 1'b1;
        end else if (clk_en) begin
            sel0_or_a0 <= p0_d;
            write_strobe_n <= p1_d;
            upper_sel_or_wr_n <= p2_d;
        end
    end

    // ------------------------------------------------------------
    // flash latch enables
    // ------------------------------------------------------------
    // copies of the two address lines, so a flash part can be watched without decoding
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_command_latch <= 1'b0;
            flash_address_latch <= 1'b0;
        end else if (clk_en) begin
            flash_command_latch <= addr_d[smblm_pkg::CLE_BIT];
            flash_address_latch <= addr_d[smblm_pkg::ALE_BIT];
        end
    end

    // ------------------------------------------------------------
    // boot configuration check
    // ------------------------------------------------------------
    // a byte-write boot chip select cannot fetch code, so it is flagged and kept quiet
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_cfg_error <= 1'b0;
        end else if (clk_en) begin
            boot_cfg_error <= boot_bad;
        end
    end

    // ------------------------------------------------------------
    // data bus
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_out <= smblm_pkg::DATA_RST;
        end else if (clk_en) begin
            data_out <= wdata_lane;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_oe <= 1'b0;
        end else if (clk_en) begin
            data_oe <= acc_valid && acc_write && !boot_bad;
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    // the read strobe reaches the pins one cycle after the request, so the bus
    // is sampled at the following edge while the strobe is still low
    logic rd_cap_q;
    logic rd_narrow_q;
    logic rd_upper_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_cap_q <= 1'b0;
            rd_narrow_q <= 1'b0;
            rd_upper_q <= 1'b0;
        end else if (clk_en) begin
            rd_cap_q <= acc_valid && !acc_write && acc_rd_pulse && !boot_bad;
            rd_narrow_q <= !wide;
            rd_upper_q <= wide && acc_size == smblm_pkg::SIZE_BYTE && acc_addr[0];
        end
    end

    // 8-bit parts return on the low lane; byte reads from the upper lane shift down
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata <= smblm_pkg::DATA_RST;
        end else if (clk_en && rd_cap_q) begin
            if (rd_narrow_q) begin
                rdata <= {8'h00, data_in[7:0]};
            end else if (rd_upper_q) begin
                rdata <= {8'h00, data_in[15:8]};
            end else begin
                rdata <= data_in;
            end
        end
    end

endmodule // smblm_top

// ### common/smblm_pkg.sv
// package of constants for the static memory byte-lane multiplexer
package smblm_pkg;
    localparam int unsigned NUM_CS = 4;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SYS_ADDR_W = 32;
    // per_cs_mode_config field positions
    localparam int unsigned MODE_W = 2;
    localparam int unsigned MODE_BUS_WIDTH_BIT = 0;
    localparam int unsigned MODE_BYTE_ACCESS_BIT = 1;
    // bus_width_select encodings
    localparam logic BW_8 = 1'b0;
    localparam logic BW_16 = 1'b1;
    // byte_access_type encodings
    localparam logic BAT_SELECT = 1'b0;
    localparam logic BAT_WRITE = 1'b1;
    // flash latch enables ride on these address lines
    localparam int unsigned CLE_BIT = 22;
    localparam int unsigned ALE_BIT = 21;
    // access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// ### test/smblm_top_checker.sv
// assertion checker for the byte-lane multiplexer pins
`timescale 1ns/1ns
module smblm_top_checker #(parameter int unsigned NUM_CS = 4) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic boot_active,
    input wire logic acc_valid,
    input wire logic [NUM_CS*smblm_pkg::MODE_W-1:0] per_cs_mode_config,
    input wire logic [$clog2(NUM_CS)-1:0] acc_cs,
    input wire logic [smblm_pkg::SYS_ADDR_W-1:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic acc_write,
    input wire logic acc_rd_pulse,
    input wire logic acc_wr_pulse,
    input wire logic flash_cmd_phase,
    input wire logic flash_addr_phase,
    input wire logic [smblm_pkg::ADDR_W-1:0] addr_pins,
    input wire logic [NUM_CS-1:0] chip_select_lines_n,
    input wire logic read_strobe_n,
    input wire logic sel0_or_a0,
    input wire logic write_strobe_n,
    input wire logic upper_sel_or_wr_n,
    input wire logic flash_command_latch,
    input wire logic flash_address_latch
);
    // ----
    // pins follow the sampled access one cycle later
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [1:0] md = per_cs_mode_config[acc_cs*2 +: 2];
    wire half = acc_size == smblm_pkg::SIZE_HALF;
    wire lo = half || !acc_addr[0];
    wire hi = half || acc_addr[0];
    sequence s_go; clk_en && acc_valid && !boot_active; endsequence
    sequence s_wr; s_go ##0 acc_write && acc_wr_pulse; endsequence
    property p_cs; s_go |=> !chip_select_lines_n[$past(acc_cs)] && $onehot(~chip_select_lines_n); endproperty
    a_cs: assert property (p_cs) else $error("chip select wrong");
    property p_addr; s_go ##0 !flash_cmd_phase && !flash_addr_phase
        |=> addr_pins == {$past(acc_addr[23:1]), $past(acc_addr[0]) && !$past(md[0])}; endproperty
    a_addr: assert property (p_addr) else $error("address wrong");
    property p_8b; s_go ##0 !md[0] |=> sel0_or_a0 == $past(acc_addr[0]) && upper_sel_or_wr_n; endproperty
    a_8b: assert property (p_8b) else $error("narrow pins wrong");
    property p_bs; s_go ##0 md == 2'h1 |=> sel0_or_a0 == !$past(lo) && upper_sel_or_wr_n == !$past(hi); endproperty
    a_bs: assert property (p_bs) else $error("byte selects wrong");
    property p_bw; s_wr ##0 md == 2'h3
        |=> sel0_or_a0 && write_strobe_n == !$past(lo) && upper_sel_or_wr_n == !$past(hi); endproperty
    a_bw: assert property (p_bw) else $error("byte writes wrong");
    property p_rd; s_go ##0 !acc_write && acc_rd_pulse |=> !read_strobe_n && write_strobe_n; endproperty
    a_rd: assert property (p_rd) else $error("read strobe wrong");
    property p_fl; s_go |=> (!$past(flash_cmd_phase) || addr_pins[22] && flash_command_latch)
        && (!$past(flash_addr_phase) || addr_pins[21] && flash_address_latch); endproperty
    a_fl: assert property (p_fl) else $error("flash latch wrong");
    property p_idle; clk_en && !acc_valid |=> &chip_select_lines_n && read_strobe_n && write_strobe_n; endproperty
    a_idle: assert property (p_idle) else $error("idle pins active");
endmodule // smblm_top_checker
bind smblm_top smblm_top_checker #(.NUM_CS(NUM_CS)) u_chk (.*);

// ### test/smblm_mem_model.sv
// small 16-bit static memory on chip select 0
`timescale 1ns/1ns
module smblm_mem_model (
    input wire logic core_clk,
    input wire logic [3:0] chip_select_lines_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic sel0_or_a0,
    input wire logic upper_sel_or_wr_n,
    input wire logic [23:0] addr_pins,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in
);
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    // only eight word lines wired, so the window aliases
    wire [7:0] wa = addr_pins[8:1];
    wire rd = !chip_select_lines_n[0] && !read_strobe_n;
    always @(posedge core_clk) begin
        if (!chip_select_lines_n[0] && !write_strobe_n && !sel0_or_a0) mem[wa][7:0] <= data_out[7:0];
        if (!chip_select_lines_n[0] && !write_strobe_n && !upper_sel_or_wr_n) mem[wa][15:8] <= data_out[15:8];
        if (rd) last <= mem[wa];
    end
    // a released bus never holds its last value
    assign data_in = rd ? mem[wa] : ~last;
endmodule // smblm_mem_model

// ### test/smblm_top_test.sv
// self-checking bench for the byte-lane multiplexer
`timescale 1ns/1ns
module smblm_top_test;
    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, boot_active = 1'b0;
    logic [7:0] per_cs_mode_config = 8'h00;
    logic acc_valid = 1'b0, acc_write = 1'b0, acc_rd_pulse = 1'b0, acc_wr_pulse = 1'b0;
    logic [1:0] acc_cs = 2'h0, acc_size = 2'h0;
    logic [31:0] acc_addr = 32'h00000000;
    logic [15:0] acc_wdata = 16'h0000, data_in, rdata, data_out;
    logic flash_cmd_phase = 1'b0, flash_addr_phase = 1'b0;
    logic [23:0] addr_pins;
    logic [3:0] chip_select_lines_n;
    logic read_strobe_n, sel0_or_a0, write_strobe_n, upper_sel_or_wr_n;
    logic data_oe, flash_command_latch, flash_address_latch, boot_cfg_error;
    int bad_count = 0, cmp_count = 0;
    initial forever #2 core_clk = ~core_clk;
    smblm_top #(.BOOT_MODE(2'h3)) dut (.*);
    smblm_mem_model u_mem (.*);
    // ----
    // drivers and scenarios
    // ----
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [1:0] c, input logic [31:0] a, input logic [1:0] s, input logic w,
        input logic [15:0] d, input logic [1:0] f);
        @(posedge core_clk);
        {acc_valid, acc_cs, acc_addr, acc_size, acc_write, acc_rd_pulse, acc_wr_pulse, acc_wdata,
            flash_cmd_phase, flash_addr_phase} <= {1'b1, c, a, s, w, !w, w, d, f};
        @(posedge core_clk);
        #1;
    endtask
    task automatic idle;
        @(posedge core_clk);
        {acc_valid, acc_rd_pulse, acc_wr_pulse, flash_cmd_phase, flash_addr_phase} <= 5'h00;
        #1;
    endtask
    task automatic t_bsel;
        acc(2'h0, 32'h00000010, 2'h1, 1'b1, 16'h1234, 2'h0);
        chk({sel0_or_a0, upper_sel_or_wr_n, write_strobe_n, addr_pins[0]}, 24'h0);
        idle;
        acc(2'h0, 32'h00000011, 2'h0, 1'b1, 16'h00ab, 2'h0);
        chk({sel0_or_a0, upper_sel_or_wr_n, write_strobe_n}, 24'h4);
        idle;
        acc(2'h0, 32'h00000210, 2'h1, 1'b0, 16'h0000, 2'h0);
        idle;
        chk(rdata, 24'hab34);
        $display("byte-select test done");
    endtask
    task automatic t_bwrite;
        acc(2'h1, 32'h00000021, 2'h0, 1'b1, 16'h005a, 2'h0);
        chk({sel0_or_a0, write_strobe_n, upper_sel_or_wr_n, data_out[15:8]}, {13'h6, 8'h5a});
        idle;
        acc(2'h1, 32'h00000020, 2'h1, 1'b1, 16'h1234, 2'h0);
        chk({sel0_or_a0, write_strobe_n, upper_sel_or_wr_n, data_oe}, 24'h9);
        idle;
        acc(2'h1, 32'h00000020, 2'h1, 1'b0, 16'h0000, 2'h0);
        chk({write_strobe_n, upper_sel_or_wr_n, read_strobe_n}, 24'h6);
        idle;
        $display("byte-write test done");
    endtask
    task automatic t_narrow;
        acc(2'h2, 32'h07fabcd5, 2'h0, 1'b0, 16'h0000, 2'h0);
        chk(addr_pins, 24'hfabcd5);
        chk({sel0_or_a0, upper_sel_or_wr_n, read_strobe_n, chip_select_lines_n}, 24'h6b);
        idle;
        acc(2'h3, 32'h00000000, 2'h1, 1'b0, 16'h0000, 2'h2);
        chk({addr_pins[22:21], flash_command_latch, flash_address_latch}, 24'ha);
        idle;
        acc(2'h3, 32'h00000000, 2'h1, 1'b0, 16'h0000, 2'h1);
        chk({addr_pins[22:21], flash_command_latch, flash_address_latch}, 24'h5);
        idle;
        $display("narrow and flash test done");
    endtask
    task automatic t_misc;
        @(posedge core_clk);
        boot_active <= 1'b1;
        acc(2'h1, 32'h00000000, 2'h1, 1'b0, 16'h0000, 2'h0);
        chk({chip_select_lines_n, read_strobe_n, boot_cfg_error}, 24'h3f);
        idle;
        @(posedge core_clk);
        boot_active <= 1'b0;
        clk_en <= 1'b0;
        acc(2'h2, 32'h00000001, 2'h0, 1'b0, 16'h0000, 2'h0);
        chk({chip_select_lines_n, read_strobe_n, boot_cfg_error}, 24'h3f);
        idle;
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(boot_cfg_error, 24'h0);
        $display("boot and clock-enable test done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        chk({chip_select_lines_n, read_strobe_n, write_strobe_n, data_oe}, 24'h7e);
        rst_n <= 1'b1;
        per_cs_mode_config <= 8'h8d;
        t_bsel;
        t_bwrite;
        t_narrow;
        t_misc;
        tally_and_finish;
    end
    // the run needs under a hundred cycles
    initial begin
        #4000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule // smblm_top_test
